/* src/lbp_pkg.sv */
// Purpose: Shared constants for the LED blink and PWM duty block.
// Assumes: 32-bit APB register bus, one aligned word per register.
// Notes:   Offsets are byte addresses.
package lbp_pkg;
  localparam int          LBP_MAIN_OUTS    = 8;
  localparam int          LBP_ALL_OUTS     = 9;
  localparam int          LBP_SLOT_CYCLES  = 16;
  localparam logic [7:0]  LBP_OFS_CTRL     = 8'h00;
  localparam logic [7:0]  LBP_OFS_PHASE0   = 8'h04;
  localparam logic [7:0]  LBP_OFS_PHASE1   = 8'h08;
  localparam logic [7:0]  LBP_OFS_NINTH    = 8'h0C;
  localparam logic [7:0]  LBP_OFS_INTENS   = 8'h10;
  localparam logic [7:0]  LBP_OFS_STATUS   = 8'h14;
  localparam int          LBP_CTRL_BLINK   = 0;
  localparam int          LBP_CTRL_MPHASE  = 1;
  localparam int          LBP_CTRL_NPHASE  = 2;
  localparam int          LBP_CTRL_MAST_LO = 4;
  localparam int          LBP_NINTH_PH0    = 0;
  localparam int          LBP_NINTH_PH1    = 1;
  localparam int          LBP_NINTH_INT_LO = 4;
  localparam int          LBP_STAT_SLOT_LO = 12;
  localparam int          LBP_STAT_RUN     = 16;
  localparam logic [3:0]  LBP_INT_STATIC   = 4'hF;
  localparam logic [3:0]  LBP_INT_HALF     = 4'h7;
  localparam logic [4:0]  LBP_LOW_FULL     = 5'h10;
  localparam logic [3:0]  LBP_RST_MASTER   = 4'hF;
  localparam logic [31:0] LBP_RST_INTENS   = 32'hFFFFFFFF;
  localparam logic [3:0]  LBP_RST_NINT     = 4'hF;
  localparam logic [7:0]  LBP_RST_PHASE    = 8'hFF;
  localparam logic        LBP_RST_NPH      = 1'b1;
endpackage

/* src/lbp_core.sv */
// Purpose: Per-output PWM duty and blink-phase mapping with an APB register file.
// Assumes: Inputs synchronous to pclk; pins are open drain, only ever driven low.
// Notes:   Blink phase is chosen by software; the ninth output has its own phase bit.
`timescale 1ns/10ps
// Functional notes
// - With blinking on and setting n below 0xF, phase bit 0 gives low time (n+1)/16 and bit 1 the complement.
// - Setting 0xF gives no PWM, static low for phase bit 0 and static release for bit 1.
// - For settings 0x0 to 0x6, bits 0 then 1 give low intensity in phase 0 and high in phase 1, and vice versa.
// - For settings 0x8 to 0xE, bits 0 then 1 give high intensity in phase 0 and low in phase 1, and vice versa.
// - Setting 0x7 gives exactly half low time in either phase.
// - The eight main outputs share phase registers, while the ninth has its own register.
// - A zero master intensity stops the PWM oscillator and drives all outputs statically.
module lbp_core
  import lbp_pkg::*;
#(
  parameter int SLOT_CYCLES = LBP_SLOT_CYCLES
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic [7:0]       led_port_out,
  output logic [7:0]       led_port_oe_n,
  output logic             ninth_port_output_out,
  output logic             ninth_port_output_oe_n
);

  logic        blink_en_r;
  logic        main_phase_r;
  logic        ninth_phase_r;
  logic [3:0]  master_r;
  logic [7:0]  phase0_r;
  logic [7:0]  phase1_r;
  logic        nph0_r;
  logic        nph1_r;
  logic [3:0]  nint_r;
  logic [31:0] intens_r;
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic [3:0]  slot_r;
  logic [$clog2(SLOT_CYCLES+1)-1:0] div_r;
  logic [8:0]  oe_n_r;
  logic        osc_run;
  logic        wr_en;
  logic        addr_ok;
  logic [31:0] rd_nxt;
  logic [8:0]  eff_bit;
  logic [3:0]  int_set [LBP_ALL_OUTS];
  logic [4:0]  low_cnt [LBP_ALL_OUTS];
  logic [8:0]  drive_low;

  // Low-time slot count out of 16 for one output.
  function automatic logic [4:0] lbp_low_slots(input logic [3:0] n, input logic bit_v);
    logic [4:0] r;
    r = 5'h00;
    if (n == LBP_INT_STATIC)
      r = bit_v ? 5'h00 : LBP_LOW_FULL;
    else if (bit_v)
      r = 5'(4'hF - n);
    else
      r = 5'({1'b0, n} + 5'h01);
    return r;
  endfunction

  assign wr_en   = psel && penable && pready_r && pwrite;
  assign addr_ok = (paddr == LBP_OFS_CTRL) || (paddr == LBP_OFS_PHASE0) || (paddr == LBP_OFS_PHASE1)
                 || (paddr == LBP_OFS_NINTH) || (paddr == LBP_OFS_INTENS) || (paddr == LBP_OFS_STATUS);
  assign osc_run = (master_r != 4'h0);

  // One wait state keeps every bus output on a flip-flop.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end
    else if (psel && penable && !pready_r)
    begin
      pready_r  <= 1'b1;
      prdata_r  <= pwrite ? 32'h00000000 : rd_nxt;
      pslverr_r <= !addr_ok;
    end
    else
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  always_comb
  begin
    rd_nxt = 32'h00000000;
    case (paddr)
      LBP_OFS_CTRL:   rd_nxt = {24'h000000, master_r, 1'b0, ninth_phase_r, main_phase_r, blink_en_r};
      LBP_OFS_PHASE0: rd_nxt = {24'h000000, phase0_r};
      LBP_OFS_PHASE1: rd_nxt = {24'h000000, phase1_r};
      LBP_OFS_NINTH:  rd_nxt = {24'h000000, nint_r, 2'b00, nph1_r, nph0_r};
      LBP_OFS_INTENS: rd_nxt = intens_r;
      LBP_OFS_STATUS: rd_nxt = {15'h0000, osc_run, slot_r, 3'h0, ~oe_n_r};
      default:        rd_nxt = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      blink_en_r    <= 1'b0;
      main_phase_r  <= 1'b0;
      ninth_phase_r <= 1'b0;
      master_r      <= LBP_RST_MASTER;
      phase0_r      <= LBP_RST_PHASE;
      phase1_r      <= LBP_RST_PHASE;
      nph0_r        <= LBP_RST_NPH;
      nph1_r        <= LBP_RST_NPH;
      nint_r        <= LBP_RST_NINT;
      intens_r      <= LBP_RST_INTENS;
    end
    else if (wr_en)
    begin
      case (paddr)
        LBP_OFS_CTRL:
        begin
          blink_en_r    <= pwdata[LBP_CTRL_BLINK];
          main_phase_r  <= pwdata[LBP_CTRL_MPHASE];
          ninth_phase_r <= pwdata[LBP_CTRL_NPHASE];
          master_r      <= pwdata[LBP_CTRL_MAST_LO +: 4];
        end
        LBP_OFS_PHASE0: phase0_r <= pwdata[7:0];
        LBP_OFS_PHASE1: phase1_r <= pwdata[7:0];
        LBP_OFS_NINTH:
        begin
          nph0_r <= pwdata[LBP_NINTH_PH0];
          nph1_r <= pwdata[LBP_NINTH_PH1];
          nint_r <= pwdata[LBP_NINTH_INT_LO +: 4];
        end
        LBP_OFS_INTENS: intens_r <= pwdata;
        default:        intens_r <= intens_r;
      endcase
    end
  end

  // oscillator stop
  // The slot counter freezes at zero so a restart always begins a fresh PWM cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_r  <= '0;
      slot_r <= 4'h0;
    end
    else if (!osc_run)
    begin
      div_r  <= '0;
      slot_r <= 4'h0;
    end
    else if (div_r == ($clog2(SLOT_CYCLES+1))'(SLOT_CYCLES - 1))
    begin
      div_r  <= '0;
      slot_r <= slot_r + 4'h1;
    end
    else
      div_r <= div_r + 1'b1;
  end

  genvar gi;
  generate
    for (gi = 0; gi < LBP_ALL_OUTS; gi++)
    begin : g_out
      if (gi < LBP_MAIN_OUTS)
      begin : g_main
        assign eff_bit[gi] = (blink_en_r && main_phase_r) ? phase1_r[gi] : phase0_r[gi];
        assign int_set[gi] = intens_r[gi*4 +: 4];
      end
      else
      begin : g_ninth
        assign eff_bit[gi] = (blink_en_r && ninth_phase_r) ? nph1_r : nph0_r;
        assign int_set[gi] = nint_r;
      end
      assign low_cnt[gi]   = lbp_low_slots(int_set[gi], eff_bit[gi]);
      assign drive_low[gi] = osc_run ? ({1'b0, slot_r} < low_cnt[gi]) : !eff_bit[gi];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      oe_n_r <= 9'h1FF;
    else
      oe_n_r <= ~drive_low;
  end

  assign pready                 = pready_r;
  assign prdata                 = prdata_r;
  assign pslverr                = pslverr_r;
  assign led_port_out           = 8'h00;
  assign led_port_oe_n          = oe_n_r[7:0];
  assign ninth_port_output_out  = 1'b0;
  assign ninth_port_output_oe_n = oe_n_r[8];

  duty_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (osc_run && int_set[0] != 4'hF && !eff_bit[0]) |-> low_cnt[0] == 5'({1'b0, int_set[0]} + 5'h01))
    else $error("Low time does not follow setting plus one.");
  duty_inv_a: assert property (@(posedge pclk) disable iff (!presetn)
    (int_set[1] != 4'hF && eff_bit[1]) |-> low_cnt[1] == 5'(4'hF - int_set[1]))
    else $error("Inverted phase low time is wrong.");
  static_full_a: assert property (@(posedge pclk) disable iff (!presetn)
    (int_set[2] == 4'hF) |=> led_port_oe_n[2] == $past(eff_bit[2]))
    else $error("Full setting is not static.");
  low_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (int_set[3] <= 4'h6 && phase0_r[3] == 1'b0 && phase1_r[3] == 1'b1 && blink_en_r && !main_phase_r)
    |-> low_cnt[3] < 5'h08)
    else $error("Low setting gives high intensity in phase zero.");
  high_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (int_set[4] >= 4'h8 && int_set[4] != 4'hF && phase0_r[4] == 1'b0 && phase1_r[4] == 1'b1
     && blink_en_r && !main_phase_r) |-> low_cnt[4] > 5'h08)
    else $error("High setting gives low intensity in phase zero.");
  half_duty_a: assert property (@(posedge pclk) disable iff (!presetn)
    (int_set[5] == LBP_INT_HALF) |-> low_cnt[5] == 5'h08)
    else $error("Half setting is not eight slots.");
  main_shared_a: assert property (@(posedge pclk) disable iff (!presetn)
    (phase0_r[6] == phase0_r[7] && phase1_r[6] == phase1_r[7] && intens_r[27:24] == intens_r[31:28])
    |=> led_port_oe_n[6] == led_port_oe_n[7])
    else $error("Matched main outputs did not switch together.");
  osc_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!osc_run) |=> (slot_r == 4'h0 && div_r == '0))
    else $error("Oscillator runs with master at zero.");

endmodule

/* verification/lbp_led_load.sv */
// Purpose: Load model for the open-drain outputs, LEDs with pull-up resistors.
// Assumes: A released pin is pulled high through its load.
// Notes:   A released pin never keeps the last driven level.
`timescale 1ns/10ps
module lbp_led_load
(
  input  wire logic [8:0] oe_n,
  input  wire logic [8:0] drv,
  output logic      [8:0] pin
);
  // The pull-up wins whenever the driver is off, so a stuck driver value stays hidden.
  assign pin = oe_n | drv;
endmodule

/* verification/tb.sv */
// Purpose: Self-checking bench for the LED blink and PWM duty block.
// Assumes: Short slots (one clock) so a PWM period is sixteen clocks.
// Notes:   Low time is counted on the loaded pins over one full period.
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  import lbp_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, lo_out, lo_oe_n;
  logic [31:0] pwdata, prdata, rd;
  logic        nn_out, nn_oe_n, er;
  logic [8:0]  pin;
  int          n_fail, tests_run, cyc;
  lbp_core #(.SLOT_CYCLES(1)) lbp_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .led_port_out(lo_out), .led_port_oe_n(lo_oe_n), .ninth_port_output_out(nn_out),
    .ninth_port_output_oe_n(nn_oe_n));
  lbp_led_load lbp_led_load_i (.oe_n({nn_oe_n, lo_oe_n}), .drv({nn_out, lo_out}), .pin(pin));
  initial
  begin
    pclk = 0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_fail++;
      complete_run();
    end
  end
  // Called right after a rising edge; returns one idle edge after the completing edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Counts low clocks of output 0 and the ninth output over one period.
  task automatic measure(input int e0, input int e8);
    int c0, c8;
    c0 = 0;
    c8 = 0;
    repeat (3) @(posedge pclk);
    repeat (LBP_SLOT_CYCLES)
    begin
      @(negedge pclk);
      c0 += (pin[0] === 1'b0);
      c8 += (pin[8] === 1'b0);
    end
    `CHK(c0, e0)
    `CHK(c8, e8)
    @(posedge pclk);
  endtask
  task automatic t_reset();
    apb(1'b0, LBP_OFS_INTENS, 32'h0);
    `CHK(rd, 32'hFFFFFFFF)
    `CHK(pin, 9'h1FF)
    apb(1'b0, 8'h18, 32'h0);
    `CHK(er, 1'b1)
    `CHK(rd, 32'h0)
  endtask
  // Phase bits 0 then 1 on every output and the ninth, checked on output 0 and the ninth, every setting, both phases.
  task automatic t_duty();
    int n, e;
    apb(1'b1, LBP_OFS_PHASE0, 32'h00);
    apb(1'b1, LBP_OFS_PHASE1, 32'hFF);
    for (n = 0; n < 16; n++)
    begin
      apb(1'b1, LBP_OFS_INTENS, {8{n[3:0]}});
      apb(1'b1, LBP_OFS_NINTH, {24'h0, n[3:0], 4'h2});
      apb(1'b1, LBP_OFS_CTRL, 32'hF1);
      e = (n < 15) ? n + 1 : 16;
      measure(e, e);
      apb(1'b1, LBP_OFS_CTRL, 32'hF7);
      e = (n < 15) ? 15 - n : 0;
      measure(e, e);
    end
  endtask
  // Main outputs move together on the shared phase; the ninth keeps its own.
  task automatic t_group();
    apb(1'b1, LBP_OFS_INTENS, 32'hFFFFFFFF);
    apb(1'b1, LBP_OFS_NINTH, 32'hF2);
    apb(1'b1, LBP_OFS_PHASE1, 32'hFF);
    apb(1'b1, LBP_OFS_CTRL, 32'hF1);
    repeat (3) @(posedge pclk);
    `CHK(pin, 9'h000)
    apb(1'b1, LBP_OFS_CTRL, 32'hF3);
    repeat (2)
    begin
      @(negedge pclk);
      `CHK(((&pin[7:0]) | (~|pin[7:0])) & ~pin[8], 1'b1)
    end
    `CHK(pin, 9'h0FF)
    // With blinking off the phase select is ignored and phase-zero bits rule.
    apb(1'b1, LBP_OFS_CTRL, 32'hF2);
    repeat (3) @(posedge pclk);
    `CHK(pin, 9'h000)
    @(posedge pclk);
  endtask
  // A zero master stops the slots: output 0 holds low, no PWM at setting 5.
  task automatic t_master0();
    apb(1'b1, LBP_OFS_INTENS, 32'hFFFFFFF5);
    apb(1'b1, LBP_OFS_NINTH, 32'h52);
    apb(1'b1, LBP_OFS_CTRL, 32'h01);
    measure(16, 16);
    apb(1'b0, LBP_OFS_STATUS, 32'h0);
    `CHK(rd[LBP_STAT_RUN], 1'b0)
  endtask
  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; n_fail = 0; tests_run = 0; cyc = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_duty();
    t_group();
    t_master0();
    complete_run();
  end
endmodule
